// ==== verilog/conditional_branch_unit.sv ====
// Decode and execution of the page-zero branch and the branch on condition
// true/false family, relative and absolute, with optional indirection.
// Assumes program memory answers a read strobe with data in the same clock,
// and that the condition code is stable at the start strobe.
// Indirect pointers are read high byte first, and every address step
// wraps inside the page it starts from.
`timescale 1ns/10ps

module conditional_branch_unit
    import branch_pkg::*;
(
    input  wire logic                ref_clk,
    input  wire logic                srst,
    input  wire logic                start,
    input  wire branch_req_t         req,
    input  wire logic [7:0]          mem_rdata,
    output logic                     mem_rd_q,
    output logic [ADDR_W-1:0]        mem_addr_q,
    output logic                     busy_q,
    output logic                     reject_q,
    output logic                     done_q,
    output branch_result_t           result_q
);

    // ==========================================================
    // State
    // ==========================================================
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_BYTE2,
        ST_BYTE3,
        ST_PTR_HI,
        ST_PTR_LO,
        ST_WAIT
    } state_t;

    // Sequencer state and its next value
    state_t             state_q,    state_d;
    branch_kind_t       kind_q,     kind_d;
    logic [ADDR_W-1:0]  base_q,     base_d;
    logic [1:0]         sel_q,      sel_d;
    logic [1:0]         cc_q,       cc_d;
    logic               ind_q,      ind_d;
    logic [ADDR_W-1:0]  ea_q,       ea_d;
    logic [7:0]         hi_q,       hi_d;
    logic [3:0]         cnt_q,      cnt_d;
    // Next values of the registered outputs
    logic               mem_rd_d;
    logic [ADDR_W-1:0]  mem_addr_d;
    logic               busy_d;
    logic               reject_d;
    logic               done_d;
    branch_result_t     result_d;

    // Decode and address arithmetic results
    branch_kind_t       dec_kind;
    logic               cond_taken;
    logic [ADDR_W-1:0]  fall_addr;
    logic [ADDR_W-1:0]  rel_ea;
    logic [ADDR_W-1:0]  zero_ea;

    // Step within a page: the page bits of the base survive
    function automatic logic [ADDR_W-1:0] page_add(input logic [ADDR_W-1:0] base,
                                                    input logic [PAGE_OFS_W-1:0] delta);
        logic [PAGE_OFS_W-1:0] low;
        low = base[PAGE_OFS_W-1:0] + delta;
        return {base[ADDR_W-1:PAGE_LSB], low};
    endfunction : page_add

    // Widen the seven-bit signed displacement to a page offset
    function automatic logic [PAGE_OFS_W-1:0] sext_offset(input logic [7:0] disp);
        logic [PAGE_OFS_W-1:0] wide;
        wide = {{(PAGE_OFS_W-OFFSET_W){disp[OFFSET_W-1]}}, disp[OFFSET_W-1:0]};
        return wide;
    endfunction : sext_offset

    // ==========================================================
    // Opcode decode
    // ==========================================================
    always_comb begin
        // Unknown patterns stay KIND_NONE and are refused
        dec_kind = KIND_NONE;
        if (req.opcode[7:3] == OPC_TRUE) begin
            dec_kind = req.opcode[OPC_MODE_BIT] ? KIND_TRUE_ABS : KIND_TRUE_REL;
        end else if (req.opcode[7:3] == OPC_FALSE) begin
            // Selector three of branch on false belongs to other instructions
            if (req.opcode[OPC_MODE_BIT]) begin
                dec_kind = (req.opcode[1:0] == SEL_ALWAYS) ? KIND_NONE : KIND_FALSE_ABS;
            end else begin
                dec_kind = (req.opcode[1:0] == SEL_ALWAYS) ? KIND_PAGE_ZERO : KIND_FALSE_REL;
            end
        end
    end

    // ==========================================================
    // Branch decision
    // ==========================================================
    always_comb begin
        // Taken or not, per kind of branch
        case (kind_q)
            KIND_PAGE_ZERO: cond_taken = 1'b1;
            KIND_TRUE_REL,
            KIND_TRUE_ABS:  cond_taken = (sel_q == SEL_ALWAYS) || (sel_q == cc_q);
            KIND_FALSE_REL,
            KIND_FALSE_ABS: cond_taken = (sel_q != cc_q);
            default:        cond_taken = 1'b0;
        endcase
    end

    // ==========================================================
    // Address arithmetic
    // ==========================================================
    always_comb begin
        // Next sequential address lies past the second byte
        fall_addr = page_add(base_q, 13'h0002);
        // Normal relative target: displacement from the following instruction
        rel_ea    = page_add(fall_addr, sext_offset(mem_rdata));
        // Page-zero target: offset from byte zero, modulo 8192, page bits cleared
        zero_ea   = {2'h0, sext_offset(mem_rdata)};
    end

    // ==========================================================
    // Sequencer next state
    // ==========================================================
    always_comb begin
        // Hold everything; strobes and pulses default low
        state_d    = state_q;
        kind_d     = kind_q;
        base_d     = base_q;
        sel_d      = sel_q;
        cc_d       = cc_q;
        ind_d      = ind_q;
        ea_d       = ea_q;
        hi_d       = hi_q;
        cnt_d      = cnt_q;
        mem_rd_d   = 1'b0;
        mem_addr_d = mem_addr_q;
        busy_d     = busy_q;
        reject_d   = 1'b0;
        done_d     = 1'b0;
        result_d   = result_q;
        // Clocks spent in the running instruction
        if (state_q != ST_IDLE) begin
            cnt_d = cnt_q + 4'h1;
        end
        case (state_q)
            // Accept a decodable request, refuse the rest
            ST_IDLE: begin
                if (start) begin
                    if (dec_kind == KIND_NONE) begin
                        reject_d = 1'b1;
                    end else begin
                        // Any page may hold the instruction
                        kind_d     = dec_kind;
                        base_d     = req.instr_addr;
                        sel_d      = req.opcode[1:0];
                        cc_d       = req.cond_code;
                        cnt_d      = CNT_RESET;
                        mem_rd_d   = 1'b1;
                        mem_addr_d = page_add(req.instr_addr, 13'h0001);
                        busy_d     = 1'b1;
                        state_d    = ST_BYTE2;
                    end
                end
            end
            // Second byte: indirect flag, displacement or high address
            ST_BYTE2: begin
                ind_d = mem_rdata[IND_BIT];
                hi_d  = mem_rdata;
                // Absolute kinds still need the third byte
                if (kind_q == KIND_TRUE_ABS || kind_q == KIND_FALSE_ABS) begin
                    mem_rd_d   = 1'b1;
                    mem_addr_d = page_add(base_q, 13'h0002);
                    state_d    = ST_BYTE3;
                end else begin
                    // Relative kinds know their target now
                    ea_d = (kind_q == KIND_PAGE_ZERO) ? zero_ea : rel_ea;
                    if (mem_rdata[IND_BIT] && cond_taken) begin
                        mem_rd_d   = 1'b1;
                        mem_addr_d = (kind_q == KIND_PAGE_ZERO) ? zero_ea : rel_ea;
                        state_d    = ST_PTR_HI;
                    end else begin
                        state_d = ST_WAIT;
                    end
                end
            end
            // Third byte completes the absolute address
            ST_BYTE3: begin
                ea_d = {hi_q[6:0], mem_rdata};
                if (ind_q && cond_taken) begin
                    mem_rd_d   = 1'b1;
                    mem_addr_d = {hi_q[6:0], mem_rdata};
                    state_d    = ST_PTR_HI;
                end else begin
                    state_d = ST_WAIT;
                end
            end
            // High byte of the pointer, then fetch its low byte
            ST_PTR_HI: begin
                hi_d       = mem_rdata;
                mem_rd_d   = 1'b1;
                mem_addr_d = page_add(ea_q, 13'h0001);
                state_d    = ST_PTR_LO;
            end
            // Low byte of the pointer completes the target
            ST_PTR_LO: begin
                ea_d    = {hi_q[6:0], mem_rdata};
                state_d = ST_WAIT;
            end
            // Pad to nine clocks, then publish the result
            ST_WAIT: begin
                if (cnt_q == LAST_CNT) begin
                    // Both the taken flag and the next instruction address leave the block
                    done_d             = 1'b1;
                    busy_d             = 1'b0;
                    result_d.taken     = cond_taken;
                    result_d.next_addr = cond_taken ? ea_q : fall_addr;
                    state_d            = ST_IDLE;
                end
            end
            default: begin
                state_d = ST_IDLE;
                busy_d  = 1'b0;
            end
        endcase
    end

    // ==========================================================
    // Sequencer registers
    // ==========================================================
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            state_q    <= ST_IDLE;
            kind_q     <= KIND_NONE;
            base_q     <= '0;
            sel_q      <= 2'h0;
            cc_q       <= 2'h0;
            ind_q      <= 1'b0;
            ea_q       <= '0;
            hi_q       <= 8'h00;
            cnt_q      <= CNT_RESET;
        end else begin
            state_q    <= state_d;
            kind_q     <= kind_d;
            base_q     <= base_d;
            sel_q      <= sel_d;
            cc_q       <= cc_d;
            ind_q      <= ind_d;
            ea_q       <= ea_d;
            hi_q       <= hi_d;
            cnt_q      <= cnt_d;
        end
    end

    // ==========================================================
    // Memory port registers
    // ==========================================================
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            mem_rd_q   <= 1'b0;
            mem_addr_q <= '0;
        end else begin
            mem_rd_q   <= mem_rd_d;
            mem_addr_q <= mem_addr_d;
        end
    end

    // ==========================================================
    // Handshake and result registers
    // ==========================================================
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            busy_q     <= 1'b0;
            reject_q   <= 1'b0;
            done_q     <= 1'b0;
            result_q   <= '0;
        end else begin
            busy_q     <= busy_d;
            reject_q   <= reject_d;
            done_q     <= done_d;
            result_q   <= result_d;
        end
    end

endmodule : conditional_branch_unit

// ==== verilog/branch_pkg.sv ====
// Constants and carrier types for the conditional branch unit.
// Assumes one 200 MHz processor clock and a program memory that returns
// read data in the same cycle as the read strobe.
package branch_pkg;

    // ==========================================================
    // Address layout
    // ==========================================================
    localparam int unsigned ADDR_W      = 15;
    localparam int unsigned PAGE_OFS_W  = 13;        // Offset within one 8192-byte page
    localparam int unsigned PAGE_LSB    = 13;        // Page-select bits 13 and 14
    localparam int unsigned OFFSET_W    = 7;         // Signed relative displacement

    // ==========================================================
    // Opcode fields
    // ==========================================================
    localparam logic [4:0] OPC_TRUE     = 5'h03;     // Bits 7..3 of branch on true
    localparam logic [4:0] OPC_FALSE    = 5'h13;     // Bits 7..3 of branch on false
    localparam int unsigned OPC_MODE_BIT = 2;        // 0 relative, 1 absolute
    localparam logic [1:0] SEL_ALWAYS   = 2'h3;      // Selector that always matches
    localparam int unsigned IND_BIT     = 7;         // Indirect flag in second byte

    // ==========================================================
    // Timing
    // ==========================================================
    localparam int unsigned CLK_PERIOD_NS   = 5;
    localparam int unsigned MACHINE_CYCLES  = 3;
    localparam int unsigned CLK_PER_MCYCLE  = 3;
    localparam int unsigned EXEC_CLKS       = MACHINE_CYCLES * CLK_PER_MCYCLE;
    localparam logic [3:0]  LAST_CNT        = 4'(EXEC_CLKS - 1);
    localparam logic [3:0]  CNT_RESET       = 4'h0;

    // ==========================================================
    // Types
    // ==========================================================
    typedef enum logic [2:0] {
        KIND_NONE,
        KIND_PAGE_ZERO,
        KIND_TRUE_REL,
        KIND_TRUE_ABS,
        KIND_FALSE_REL,
        KIND_FALSE_ABS
    } branch_kind_t;

    typedef struct packed {
        logic [7:0]        opcode;
        logic [ADDR_W-1:0] instr_addr;   // Address of the opcode byte
        logic [1:0]        cond_code;    // Condition code of the status word
    } branch_req_t;

    typedef struct packed {
        logic              taken;
        logic [ADDR_W-1:0] next_addr;
    } branch_result_t;

endpackage : branch_pkg

// ==== tb/branch_mem_model.sv ====
// Program memory model facing the branch unit.
// Assumes the read data is sampled at the edge that ends the strobe cycle.
`timescale 1ns/10ps
module branch_mem_model
    import branch_pkg::*;
(
    input  wire logic              ref_clk,
    input  wire logic              mem_rd_q,
    input  wire logic [ADDR_W-1:0] mem_addr_q,
    output logic      [7:0]        mem_rdata
);
    logic [7:0] store [0:(2**ADDR_W)-1];
    logic [7:0] last_q;
    // Remember the byte on the bus
    always_ff @(posedge ref_clk) begin
        last_q <= mem_rdata;
    end
    // Unread cycles show the inverse of the last bus value, so a stale byte returns on every second unread cycle
    assign mem_rdata = mem_rd_q ? store[mem_addr_q] : ~last_q;
endmodule : branch_mem_model

// ==== tb/conditional_branch_unit_properties.sv ====
// Concurrent checks on the ports of the branch unit.
// Assumes the one clock and the synchronous reset of the unit.
`timescale 1ns/10ps
module conditional_branch_unit_properties
    import branch_pkg::*;
(
    input wire logic              ref_clk,
    input wire logic              srst,
    input wire logic              start,
    input wire branch_req_t       req,
    input wire logic [7:0]        mem_rdata,
    input wire logic              mem_rd_q,
    input wire logic [ADDR_W-1:0] mem_addr_q,
    input wire logic              busy_q,
    input wire logic              reject_q,
    input wire logic              done_q,
    input wire branch_result_t    result_q
);
    logic              dec, acc, tk, first_q;
    logic [1:0]        sel;
    logic [7:0]        b2_q;
    branch_req_t       rq_q;
    logic [ADDR_W-1:0] fall, rel;
    // ==========================================================
    // Expected outcome of the accepted request
    // ==========================================================
    assign dec  = (req.opcode[7:3] == OPC_TRUE) || (req.opcode[7:3] == OPC_FALSE && req.opcode != 8'h9F);
    assign acc  = start && !busy_q && dec;
    assign sel  = rq_q.opcode[1:0];
    assign tk   = (rq_q.opcode == 8'h9B) || ((rq_q.opcode[7:3] == OPC_TRUE) ?
                  (sel == rq_q.cond_code || sel == SEL_ALWAYS) : (sel != rq_q.cond_code));
    assign fall = {rq_q.instr_addr[14:13], rq_q.instr_addr[12:0] + 13'h2};
    assign rel  = {rq_q.instr_addr[14:13], rq_q.instr_addr[12:0] + 13'h2 + {{6{b2_q[6]}}, b2_q[6:0]}};
    // Capture the request and its second byte
    always_ff @(posedge ref_clk) begin
        first_q <= acc && !srst;
        if (acc) rq_q <= req;
        if (first_q) b2_q <= mem_rdata;
    end
    // ==========================================================
    // Properties
    // ==========================================================
    default clocking @(posedge ref_clk); endclocking
    default disable iff (srst);
    sequence s_run; (busy_q && !done_q) [*8] ##1 (busy_q && !done_q); endsequence // Nine busy clocks
    sequence s_end; done_q && !busy_q; endsequence
    a_exec_nine: assert property (acc |=> s_run ##1 s_end) else $error("branch length wrong");
    a_reject_bad: assert property (start && !busy_q && !dec |=> reject_q && !busy_q && !done_q)
        else $error("bad opcode not refused");
    a_first_fetch: assert property (acc |=> mem_rd_q && mem_addr_q == {rq_q.instr_addr[14:13],
        rq_q.instr_addr[12:0] + 13'h1}) else $error("first fetch wrong");
    a_taken_code: assert property (done_q |-> result_q.taken == tk) else $error("taken flag wrong");
    a_fall_through: assert property (done_q && !tk |-> result_q.next_addr == fall)
        else $error("fall-through wrong");
    a_rel_target: assert property (done_q && tk && !b2_q[7] && !rq_q.opcode[2] && rq_q.opcode != 8'h9B
        |-> result_q.next_addr == rel) else $error("relative target wrong");
    a_page_zero: assert property (done_q && rq_q.opcode == 8'h9B |-> b2_q[7] ||
        result_q.next_addr == {2'h0, {6{b2_q[6]}}, b2_q[6:0]}) else $error("page-zero target wrong");
    a_result_hold: assert property (!done_q |-> $stable(result_q)) else $error("result moved");
endmodule : conditional_branch_unit_properties

bind conditional_branch_unit conditional_branch_unit_properties conditional_branch_unit_properties_inst (
    .ref_clk(ref_clk), .srst(srst), .start(start), .req(req), .mem_rdata(mem_rdata), .mem_rd_q(mem_rd_q),
    .mem_addr_q(mem_addr_q), .busy_q(busy_q), .reject_q(reject_q), .done_q(done_q), .result_q(result_q));

// ==== tb/conditional_branch_unit_test.sv ====
// Self-checking bench for the branch unit with a program memory model.
// Assumes a 200 MHz clock and 16 reset cycles at the start.
`timescale 1ns/10ps
module conditional_branch_unit_test
    import branch_pkg::*;
;
    logic              ref_clk = 1'b0;
    logic              srst, start, mem_rd_q, busy_q, reject_q, done_q;
    logic [7:0]        mem_rdata;
    logic [ADDR_W-1:0] mem_addr_q;
    branch_req_t       req;
    branch_result_t    result_q;
    int                fails = 0;
    int                total_checks = 0;
    // Clock
    always #2.5 ref_clk = ~ref_clk;
    conditional_branch_unit conditional_branch_unit_inst (.ref_clk(ref_clk), .srst(srst), .start(start),
        .req(req), .mem_rdata(mem_rdata), .mem_rd_q(mem_rd_q), .mem_addr_q(mem_addr_q), .busy_q(busy_q),
        .reject_q(reject_q), .done_q(done_q), .result_q(result_q));
    branch_mem_model branch_mem_model_inst (.ref_clk(ref_clk), .mem_rd_q(mem_rd_q), .mem_addr_q(mem_addr_q),
        .mem_rdata(mem_rdata));
    // ==========================================================
    // Shared tasks
    // ==========================================================
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH %s expected %0h seen %0h", name, exp, seen);
        end
    endtask : check
    task automatic report_and_stop;
        if (fails == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : report_and_stop
    task automatic run(input logic [7:0] op, input logic [14:0] a, input logic [1:0] cc, input logic [7:0] b2,
                       input logic [7:0] b3, input logic tk, input logic [14:0] na);
        int n;
        branch_mem_model_inst.store[a + 15'h1] = b2;
        branch_mem_model_inst.store[a + 15'h2] = b3;
        @(posedge ref_clk);
        start <= 1'b1;
        req   <= '{op, a, cc};
        @(posedge ref_clk);
        start <= 1'b0;
        n = 0;
        while (done_q !== 1'b1 && n < 20) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        check("cycles", 32'(n), 32'h9);
        if (n >= 20) report_and_stop();
        check("taken", 32'(result_q.taken), 32'(tk));
        check("next_addr", 32'(result_q.next_addr), 32'(na));
    endtask : run
    // ==========================================================
    // Scenarios
    // ==========================================================
    task automatic t_cond_codes;
        logic tk;
        for (int f = 0; f < 2; f++) for (int m = 0; m < 2; m++) for (int s = 0; s < 4; s++)
            for (int c = 0; c < 4; c++) begin
                tk = f ? (s != c) : (s == c || s == 3);
                if (!(f == 1 && s == 3))
                    run(8'(f * 128 + 24 + m * 4 + s), 15'h2100, 2'(c), 8'h12, 8'h34, tk,
                        tk ? (m ? 15'h1234 : 15'h2114) : 15'h2102);
            end
    endtask : t_cond_codes
    task automatic t_page_zero;
        run(8'h9B, 15'h6000, 2'h0, 8'h78, 8'h00, 1'b1, 15'h1FF8);
        run(8'h9B, 15'h7FF0, 2'h3, 8'h34, 8'h00, 1'b1, 15'h0034);
    endtask : t_page_zero
    task automatic t_indirect;
        branch_mem_model_inst.store[15'h0207] = 8'h21;
        branch_mem_model_inst.store[15'h0208] = 8'h43;
        branch_mem_model_inst.store[15'h1010] = 8'h05;
        branch_mem_model_inst.store[15'h1011] = 8'h66;
        branch_mem_model_inst.store[15'h1FF8] = 8'h3A;
        branch_mem_model_inst.store[15'h1FF9] = 8'h11;
        run(8'h1B, 15'h0200, 2'h0, 8'h85, 8'h00, 1'b1, 15'h2143);
        run(8'h9C, 15'h0300, 2'h1, 8'h90, 8'h10, 1'b1, 15'h0566);
        run(8'h9B, 15'h4000, 2'h2, 8'hF8, 8'h00, 1'b1, 15'h3A11);
    endtask : t_indirect
    task automatic t_reject;
        logic [7:0] ops [2] = '{8'h9F, 8'h20};
        foreach (ops[i]) begin
            @(posedge ref_clk);
            start <= 1'b1;
            req   <= '{ops[i], 15'h0100, 2'h0};
            @(posedge ref_clk);
            start <= 1'b0;
            #1;
            check("reject", 32'(reject_q), 32'h1);
            check("busy", 32'(busy_q), 32'h0);
        end
    endtask : t_reject
    // Main sequence
    initial begin
        srst  = 1'b1;
        start = 1'b0;
        req   = '0;
        repeat (16) @(posedge ref_clk);
        srst <= 1'b0;
        @(posedge ref_clk);
        #1;
        check("idle", 32'({busy_q, done_q, reject_q, result_q}), 32'h0);
        t_cond_codes();
        t_page_zero();
        t_indirect();
        t_reject();
        report_and_stop();
    end
endmodule : conditional_branch_unit_test
